// *** hdl/aux_output_sequencing_config.sv ***
// Purpose: register bank and sequencing for two auxiliary outputs
// Assumes: serial interface decoded upstream into an 8-bit register port
// Notes: pins shown as level, output enable and pull selects
`timescale 1ns/1ns
`default_nettype none
module aux_output_sequencing_config (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic enablePin,
  output logic [7:0] regRdata,
  output logic regReadValid,
  output logic firstAuxOutput,
  output logic firstAuxOutputOe,
  output logic secondAuxOutput,
  output logic secondAuxOutputOe,
  output logic sharedPinIsClock,
  output logic sharedPinPulldown,
  output logic sequencePinPulldown,
  output logic thermalWarningHigh,
  output logic spreadSwitchingOn,
  output logic syncEnable,
  output logic [4:0] syncClockFreqCode
);
  typedef struct packed {
    logic [7:0] edgeDelay;
    logic [7:0] outCtrl;
    logic [7:0] genConfig;
    logic [7:0] syncCtrl;
    logic [7:0] rdata;
    logic rvalid;
    logic aux1;
    logic aux1Oe;
    logic aux2;
    logic aux2Oe;
  } aux_top_t;
  aux_top_t state;
  aux_top_t next_state;
  logic tick;
  logic seq1On;
  logic seq2On;
  aux_tick u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick)
  );
  // first output has no delay register here; it follows enable with zero delay
  aux_seq u_seq1 (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick),
    .enablePin(enablePin),
    .riseCode(4'h0),
    .fallCode(4'h0),
    .riseRange(state.genConfig[aux_pkg::RISE_RANGE_BIT]),
    .fallRange(state.genConfig[aux_pkg::FALL_RANGE_BIT]),
    .seqOn(seq1On)
  );
  aux_seq u_seq2 (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick),
    .enablePin(enablePin),
    .riseCode(state.edgeDelay[aux_pkg::RISE_CODE_LSB +: 4]),
    .fallCode(state.edgeDelay[aux_pkg::FALL_CODE_LSB +: 4]),
    .riseRange(state.genConfig[aux_pkg::RISE_RANGE_BIT]),
    .fallRange(state.genConfig[aux_pkg::FALL_RANGE_BIT]),
    .seqOn(seq2On)
  );
  // resolve requested level and drive type into pin level and enable
  function automatic logic [1:0] drivePin(input logic level, input logic openDrain);
    drivePin = openDrain ? {1'b0, ~level} : {level, 1'b1};
  endfunction
  logic req1;
  logic req2;
  logic [1:0] pin1;
  logic [1:0] pin2;
  always_comb begin
    req1 = state.outCtrl[aux_pkg::AUX1_LEVEL_BIT];
    if (state.outCtrl[aux_pkg::AUX1_FOLLOW_BIT]) begin
      req1 = req1 & seq1On;
    end
    req2 = state.outCtrl[aux_pkg::AUX2_LEVEL_BIT];
    if (state.outCtrl[aux_pkg::AUX2_FOLLOW_BIT]) begin
      req2 = req2 & seq2On;
    end
    pin1 = drivePin(req1, state.outCtrl[aux_pkg::AUX1_DRIVE_BIT]);
    pin2 = drivePin(req2, state.outCtrl[aux_pkg::AUX2_DRIVE_BIT]);
    // clock input function releases the pin entirely
    if (state.genConfig[aux_pkg::PIN_FUNCTION_BIT]) begin
      pin2 = 2'h0;
    end
  end
  always_comb begin
    next_state = state;
    next_state.aux1 = pin1[1];
    next_state.aux1Oe = pin1[0];
    next_state.aux2 = pin2[1];
    next_state.aux2Oe = pin2[0];
    next_state.rvalid = regRead;
    if (regWrite) begin
      case (regAddr)
        aux_pkg::ADDR_AUX2_EDGE_DELAY: next_state.edgeDelay = regWdata;
        aux_pkg::ADDR_AUX_OUTPUT_CONTROL: begin
          next_state.outCtrl = regWdata & aux_pkg::MASK_AUX_OUTPUT_CONTROL;
        end
        aux_pkg::ADDR_GENERAL_CONFIG: begin
          next_state.genConfig = regWdata & aux_pkg::MASK_GENERAL_CONFIG;
        end
        // software keeps the code in range; stored as written
        aux_pkg::ADDR_CLOCK_SYNC_CONTROL: begin
          next_state.syncCtrl = regWdata & aux_pkg::MASK_CLOCK_SYNC_CONTROL;
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        aux_pkg::ADDR_AUX2_EDGE_DELAY: next_state.rdata = state.edgeDelay;
        aux_pkg::ADDR_AUX_OUTPUT_CONTROL: next_state.rdata = state.outCtrl;
        aux_pkg::ADDR_GENERAL_CONFIG: next_state.rdata = state.genConfig;
        aux_pkg::ADDR_CLOCK_SYNC_CONTROL: next_state.rdata = state.syncCtrl;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state.edgeDelay <= aux_pkg::RST_AUX2_EDGE_DELAY;
      state.outCtrl <= aux_pkg::RST_AUX_OUTPUT_CONTROL;
      state.genConfig <= aux_pkg::RST_GENERAL_CONFIG;
      state.syncCtrl <= aux_pkg::RST_CLOCK_SYNC_CONTROL;
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
      state.aux1 <= 1'b0;
      state.aux1Oe <= 1'b0;
      state.aux2 <= 1'b0;
      state.aux2Oe <= 1'b0;
    end else begin
      state <= next_state;
    end
  end
  assign regRdata = state.rdata;
  assign regReadValid = state.rvalid;
  assign firstAuxOutput = state.aux1;
  assign firstAuxOutputOe = state.aux1Oe;
  assign secondAuxOutput = state.aux2;
  assign secondAuxOutputOe = state.aux2Oe;
  assign sharedPinIsClock = state.genConfig[aux_pkg::PIN_FUNCTION_BIT];
  assign sharedPinPulldown = state.genConfig[aux_pkg::SHARED_PULLDOWN_BIT];
  assign sequencePinPulldown = state.genConfig[aux_pkg::SEQ_PULLDOWN_BIT];
  assign thermalWarningHigh = state.genConfig[aux_pkg::THERMAL_LEVEL_BIT];
  assign spreadSwitchingOn = state.genConfig[aux_pkg::SPREAD_BIT];
  assign syncEnable = state.syncCtrl[aux_pkg::SYNC_ENABLE_BIT];
  assign syncClockFreqCode = state.syncCtrl[aux_pkg::FREQ_CODE_LSB +: 5];
endmodule // aux_output_sequencing_config
`default_nettype wire

// *** hdl/aux_pkg.sv ***
// Purpose: shared constants for the auxiliary output sequencing block
// Assumes: 8-bit register port, 125 MHz mclk
// Notes: one name per number
package aux_pkg;
  localparam logic [7:0] ADDR_AUX2_EDGE_DELAY = 8'h11;
  localparam logic [7:0] ADDR_AUX_OUTPUT_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h13;
  localparam logic [7:0] ADDR_CLOCK_SYNC_CONTROL = 8'h14;
  localparam logic [7:0] RST_AUX2_EDGE_DELAY = 8'h02;
  localparam logic [7:0] RST_AUX_OUTPUT_CONTROL = 8'h77;
  localparam logic [7:0] RST_GENERAL_CONFIG = 8'h06;
  localparam logic [7:0] RST_CLOCK_SYNC_CONTROL = 8'h01;
  localparam logic [7:0] MASK_AUX_OUTPUT_CONTROL = 8'h77;
  localparam logic [7:0] MASK_GENERAL_CONFIG = 8'hFF;
  localparam logic [7:0] MASK_CLOCK_SYNC_CONTROL = 8'hFF;
  localparam int FALL_CODE_LSB = 4;
  localparam int RISE_CODE_LSB = 0;
  localparam int AUX2_DRIVE_BIT = 6;
  localparam int AUX2_FOLLOW_BIT = 5;
  localparam int AUX2_LEVEL_BIT = 4;
  localparam int AUX1_DRIVE_BIT = 2;
  localparam int AUX1_FOLLOW_BIT = 1;
  localparam int AUX1_LEVEL_BIT = 0;
  localparam int RISE_RANGE_BIT = 6;
  localparam int FALL_RANGE_BIT = 5;
  localparam int PIN_FUNCTION_BIT = 4;
  localparam int SHARED_PULLDOWN_BIT = 3;
  localparam int SEQ_PULLDOWN_BIT = 2;
  localparam int THERMAL_LEVEL_BIT = 1;
  localparam int SPREAD_BIT = 0;
  localparam int SYNC_ENABLE_BIT = 6;
  localparam int FREQ_CODE_LSB = 0;
  localparam int MCLK_MHZ = 125;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES = TICK_US * MCLK_MHZ;
  typedef enum logic [1:0] {AUX_IDLE, AUX_RISE_WAIT, AUX_FALL_WAIT} aux_seq_t;
endpackage

// *** hdl/aux_tick.sv ***
// Purpose: 0.5 ms timebase pulse
// Assumes: mclk 125 MHz
// Notes: free running, shared by both sequencers
`timescale 1ns/1ns
`default_nettype none
module aux_tick #(
  parameter int TICK_CYCLES = aux_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  output logic tick
);
  typedef struct packed {
    logic [16:0] count;
    logic tick;
  } aux_tick_t;
  aux_tick_t state;
  aux_tick_t next_state;
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 17'(TICK_CYCLES - 1)) begin
      next_state.count = 17'h00000;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 17'h00001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign tick = state.tick;
endmodule // aux_tick
`default_nettype wire

// *** hdl/aux_seq.sv ***
// Purpose: one output's enable-following delay sequencer
// Assumes: tick every 0.5 ms, enable synchronous
// Notes: new enable edge restarts the wait
`timescale 1ns/1ns
`default_nettype none
module aux_seq (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic enablePin,
  input wire logic [3:0] riseCode,
  input wire logic [3:0] fallCode,
  input wire logic riseRange,
  input wire logic fallRange,
  output logic seqOn
);
  typedef struct packed {
    aux_pkg::aux_seq_t fsm;
    logic [4:0] ticksLeft;
    logic enPrev;
    logic on;
  } aux_seq_st_t;
  aux_seq_st_t state;
  aux_seq_st_t next_state;
  // code steps of 0.5 ms ticks, doubled for the 1 ms range
  function automatic logic [4:0] ticksFor(input logic [3:0] code, input logic range);
    ticksFor = range ? {code, 1'b0} : {1'b0, code};
  endfunction
  always_comb begin
    next_state = state;
    next_state.enPrev = enablePin;
    if (enablePin && !state.enPrev) begin
      next_state.fsm = aux_pkg::AUX_RISE_WAIT;
      next_state.ticksLeft = ticksFor(riseCode, riseRange);
    end else if (!enablePin && state.enPrev) begin
      next_state.fsm = aux_pkg::AUX_FALL_WAIT;
      next_state.ticksLeft = ticksFor(fallCode, fallRange);
    end else begin
      case (state.fsm)
        aux_pkg::AUX_RISE_WAIT, aux_pkg::AUX_FALL_WAIT: begin
          if (state.ticksLeft == 5'h00) begin
            next_state.on = (state.fsm == aux_pkg::AUX_RISE_WAIT);
            next_state.fsm = aux_pkg::AUX_IDLE;
          end else if (tick) begin
            next_state.ticksLeft = state.ticksLeft - 5'h01;
          end
        end
        aux_pkg::AUX_IDLE: begin
        end
        default: begin
          next_state.fsm = aux_pkg::AUX_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign seqOn = state.on;
endmodule // aux_seq
`default_nettype wire

// *** tb/aux_chk.sv ***
// Purpose: port checks for the aux block
// Assumes: sync active-low reset
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module aux_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regReadValid,
  input wire logic firstAuxOutput,
  input wire logic firstAuxOutputOe,
  input wire logic secondAuxOutput,
  input wire logic secondAuxOutputOe,
  input wire logic sharedPinIsClock,
  input wire logic sharedPinPulldown,
  input wire logic sequencePinPulldown,
  input wire logic thermalWarningHigh,
  input wire logic spreadSwitchingOn,
  input wire logic syncEnable,
  input wire logic [4:0] syncClockFreqCode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // a second write to the same place would hide the first
  sequence wr_idle(a);
    regWrite && regAddr == a ##1 !(regWrite && regAddr == a);
  endsequence
  a_read_answer: assert property (regRead |=> regReadValid)
    else $error("read not answered");
  a_unmapped_zero: assert property (regRead && (regAddr < 8'h11 || regAddr > 8'h14)
    |=> regRdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (regRead && regAddr == 8'h12 |=>
    regRdata[7] == 1'b0 && regRdata[3] == 1'b0) else $error("reserved bit set");
  a_sync_fields: assert property (wr_idle(8'h14) |=>
    {1'b0, syncEnable, 1'b0, syncClockFreqCode} == ($past(regWdata, 2) & 8'h5F))
    else $error("sync outputs wrong");
  a_config_bits: assert property (wr_idle(8'h13) |=>
    {3'h0, sharedPinIsClock, sharedPinPulldown, sequencePinPulldown, thermalWarningHigh,
    spreadSwitchingOn} == ($past(regWdata, 2) & 8'h1F)) else $error("config outputs wrong");
  a_clock_pin_oe: assert property (sharedPinIsClock [*2] |-> !secondAuxOutputOe)
    else $error("clock pin driven");
  a_pp_first: assert property (firstAuxOutput |-> firstAuxOutputOe)
    else $error("aux1 high undriven");
  a_pp_second: assert property (secondAuxOutput |-> secondAuxOutputOe)
    else $error("aux2 high undriven");
endmodule // aux_chk
bind aux_output_sequencing_config aux_chk aux_chk_i (.*);
`default_nettype wire

// *** tb/aux_host.sv ***
// Purpose: host model, register strobes and enable pin
// Assumes: drives on the falling edge
// Notes: released address and data are inverted
`timescale 1ns/1ns
`default_nettype none
module aux_host (
  input wire logic mclk,
  input wire logic [7:0] regRdata,
  input wire logic regReadValid,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic enablePin
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    enablePin = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    // stale bus values must not be relied on
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    regAddr = ~a;
    d = regReadValid ? regRdata : 8'hXX;
  endtask
  task automatic pin(input logic v);
    @(negedge mclk);
    enablePin = v;
  endtask
endmodule // aux_host
`default_nettype wire

// *** tb/test_aux_output_sequencing_config.sv ***
// Purpose: self-checking bench for the aux block
// Assumes: full-length 0.5 ms tick
// Notes: one delay run spans a whole tick
`timescale 1ns/1ns
`default_nettype none
module test_aux_output_sequencing_config;
  logic mclk, reset_n, regWrite, regRead, enablePin, regReadValid, firstAuxOutput;
  logic firstAuxOutputOe, secondAuxOutput, secondAuxOutputOe, sharedPinIsClock;
  logic sharedPinPulldown, sequencePinPulldown, thermalWarningHigh, spreadSwitchingOn;
  logic syncEnable;
  logic [4:0] syncClockFreqCode;
  logic [7:0] regAddr, regWdata, regRdata, a, d, got;
  logic [1:0] e;
  logic [7:0] dflt [6] = '{8'h00, 8'h02, 8'h77, 8'h06, 8'h01, 8'h00};
  logic [15:0] corner [3] = '{16'h1457, 16'h12FF, 16'h13FF};
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 82;
  int cyc = 0;
  int n;
  wire logic [7:0] pins = {4'h0, firstAuxOutput, firstAuxOutputOe, secondAuxOutput,
    secondAuxOutputOe};
  wire logic [7:0] cfg = {3'h0, sharedPinIsClock, sharedPinPulldown, sequencePinPulldown,
    thermalWarningHigh, spreadSwitchingOn};
  wire logic [7:0] sync = {1'b0, syncEnable, 1'b0, syncClockFreqCode};
  aux_output_sequencing_config aux_output_sequencing_config_i (.*);
  aux_host aux_host_i (.*);
  function automatic logic [7:0] rbk(input logic [7:0] ad, input logic [7:0] v);
    if (ad == 8'h12) return v & 8'h77;
    return (ad >= 8'h11 && ad <= 8'h14) ? v : 8'h00;
  endfunction
  function automatic logic [1:0] drv(input logic od, fol, lvl, en);
    logic req;
    req = lvl & (en | ~fol);
    return od ? {1'b0, ~req} : {req, 1'b1};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      aux_host_i.rd(8'h10 + 8'(i), got);
      chk("reset value", dflt[i], got);
    end
    chk("reset pins", 8'h05, pins);
    chk("reset config", 8'h06, cfg);
    chk("reset sync", 8'h01, sync);
    $display("reset test done");
    for (int k = 0; k < 20; k++) begin
      a = 8'h10 + (8'($random(seed)) & 8'h07);
      d = 8'($random(seed));
      if (k < 3) {a, d} = corner[k];
      if (a == 8'h14) d[4:0] = d[4:0] % 5'd24;
      aux_host_i.wr(a, d);
      aux_host_i.rd(a, got);
      chk("readback", rbk(a, d), got);
      @(negedge mclk);
      if (a == 8'h13) chk("config pins", {3'h0, d[4:0]}, cfg);
      if (a == 8'h14) chk("sync fields", d & 8'h5F, sync);
    end
    $display("register test done");
    aux_host_i.wr(8'h11, 8'h00);
    aux_host_i.wr(8'h13, 8'h00);
    for (int m = 0; m < 16; m++) begin
      aux_host_i.wr(8'h12, {1'b0, 3'(m), 1'b0, 3'(m)});
      aux_host_i.pin(m[3]);
      repeat (6) @(negedge mclk);
      e = drv(m[2], m[1], m[0], m[3]);
      chk("output drive", {4'h0, e, e}, pins);
    end
    aux_host_i.wr(8'h12, 8'h33);
    aux_host_i.wr(8'h13, 8'h10);
    repeat (3) @(negedge mclk);
    chk("clock pin drive", 8'h00, {7'h0, secondAuxOutputOe});
    $display("drive test done");
    aux_host_i.wr(8'h13, 8'h00);
    aux_host_i.wr(8'h11, 8'h01);
    aux_host_i.pin(1'b0);
    repeat (6) @(negedge mclk);
    chk("fall code zero", 8'h05, pins);
    aux_host_i.pin(1'b1);
    repeat (6) @(negedge mclk);
    // second output must still be waiting out its 0.5 ms rise code
    chk("first at once", 8'h02, {6'h0, firstAuxOutput, secondAuxOutput});
    n = 0;
    // code 1 may take up to one full tick
    while (secondAuxOutput !== 1'b1 && n < 62600) begin
      @(negedge mclk);
      n++;
    end
    chk("rise delay", 8'h01, {7'h0, secondAuxOutput});
    $display("delay test done");
    tally_and_finish();
  end
endmodule // test_aux_output_sequencing_config
`default_nettype wire
